/* logic/config_unlock_index_data_port.sv */
/*
 * Configuration access logic: unlock key sequence, index port and data
 * port on an ISA-style I/O bus, with global and per-device register banks.
 * Assumes bus pins are asynchronous to clock; rst is the cold (master)
 * reset, warm_rst a pin that restarts the access sequence and clears the index.
 */
`timescale 1ns/100ps
module config_unlock_index_data_port #(
	parameter logic [7:0] BANK_LAST = cfg_pkg::IDX_RANGE_HI
) (
	input  wire logic                      clock,
	input  wire logic                      rst,
	input  wire logic                      warm_rst,
	input  wire logic                      port_select_strap_pin,
	input  wire logic                      isa_aen,
	input  wire logic [cfg_pkg::ADDR_W-1:0] isa_addr,
	input  wire logic                      isa_iow_n,
	input  wire logic                      isa_ior_n,
	input  wire logic [7:0]                isa_data_in,
	output logic      [7:0]                isa_data_out,
	output logic                           isa_data_oe_n,
	output logic                           config_mode,
	output logic      [7:0]                logical_device,
	output logic                           config_port_select
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		cfg_pkg::mode_e mode;
		logic [7:0]     index;
		logic [7:0]     ldn;
		logic [7:0]     option;
		logic [1:0]     strap_cnt;
		logic           iow_prev;
		logic [7:0]     dout;
		logic           oe_n;
	} state_s;

	state_s         s_r;
	state_s         s_nxt;
	cfg_pkg::pins_s pins_raw;
	cfg_pkg::pins_s pins;
	logic [7:0]     dev_rd [cfg_pkg::LDN_COUNT];
	logic [7:0]     glob_rd;
	logic           bank_wr;
	logic           glob_wr;
	logic           io_write;
	logic           io_read;
	logic           at_index;
	logic           at_data;
	logic           idx_valid;
	logic           locked;
	logic [7:0]     rd_value;
	logic           strap_busy;
	logic           strap_take;

	initial
	begin
		if (BANK_LAST < cfg_pkg::IDX_BANK_LO || BANK_LAST > cfg_pkg::IDX_RANGE_HI)
			$error("BANK_LAST outside the banked index range");
		if (cfg_pkg::LDN_COUNT > 16 || cfg_pkg::LDN_SKIPPED >= cfg_pkg::LDN_COUNT)
			$error("device count does not fit the four-bit bank select");
		if (cfg_pkg::STRAP_TAKE < 2'h2 || cfg_pkg::STRAP_TAKE >= cfg_pkg::STRAP_DONE)
			$error("strap count must let the synchroniser fill first");
	end

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	assign pins_raw = '{warm_rst: warm_rst, strap: port_select_strap_pin,
		aen: isa_aen, iow_n: isa_iow_n, ior_n: isa_ior_n,
		addr: isa_addr, data: isa_data_in};

	sync2 #(
		.WIDTH     ($bits(cfg_pkg::pins_s)),
		.RESET_VAL (cfg_pkg::PINS_IDLE)
	) u_pin_sync (
		.clock (clock),
		.rst   (rst),
		.d     (pins_raw),
		.q     (pins)
	);

	// ------------------------------------------------------------
	// register banks
	// ------------------------------------------------------------
	cfg_byte_bank #(
		.FIRST (cfg_pkg::IDX_GLOBAL_CTRL),
		.LAST  (cfg_pkg::IDX_GLOBAL_LAST)
	) u_global_bank (
		.clock   (clock),
		.rst     (rst),
		.wr_en   (glob_wr),
		.idx     (s_r.index),
		.wr_data (pins.data),
		.rd_data (glob_rd)
	);

	// one bank per device number; number four has none
	for (genvar g = 0; g < cfg_pkg::LDN_COUNT; g++)
	begin : g_dev
		if (g == cfg_pkg::LDN_SKIPPED)
		begin : g_absent
			assign dev_rd[g] = 8'h00;
		end
		else
		begin : g_present
			logic dev_wr;

			assign dev_wr = bank_wr && (s_r.ldn == 8'(g));

			cfg_byte_bank #(
				.FIRST (cfg_pkg::IDX_BANK_LO),
				.LAST  (BANK_LAST)
			) u_bank (
				.clock   (clock),
				.rst     (rst),
				.wr_en   (dev_wr),
				.idx     (s_r.index),
				.wr_data (pins.data),
				.rd_data (dev_rd[g])
			);
		end
	end

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	// the port pair follows option bit 6 at once
	always_comb
	begin
		if (s_r.option[cfg_pkg::OPT_PORT_SEL_BIT])
		begin
			at_index = !pins.aen && (pins.addr == cfg_pkg::BASE_ALT);
			at_data  = !pins.aen && (pins.addr == cfg_pkg::DATA_ALT);
		end
		else
		begin
			at_index = !pins.aen && (pins.addr == cfg_pkg::BASE_PRIMARY);
			at_data  = !pins.aen && (pins.addr == cfg_pkg::DATA_PRIMARY);
		end
	end

	// write taken at the trailing edge of the write strobe
	assign io_write = !s_r.iow_prev && pins.iow_n;
	assign io_read  = !pins.ior_n && at_data && (s_r.mode == cfg_pkg::MODE_EXT);
	assign locked   = s_r.option[cfg_pkg::OPT_LOCK_BIT];

	// index FF lies outside the valid range
	assign idx_valid = (s_r.index == cfg_pkg::IDX_GLOBAL_CTRL)
		|| ((s_r.index >= cfg_pkg::IDX_RANGE_LO)
		&& (s_r.index <= cfg_pkg::IDX_RANGE_HI));

	// ------------------------------------------------------------
	// strap capture
	// ------------------------------------------------------------
	// the pin synchroniser shows the strap only two edges after reset
	assign strap_busy = (s_r.strap_cnt != cfg_pkg::STRAP_DONE);
	assign strap_take = (s_r.strap_cnt == cfg_pkg::STRAP_TAKE);

	// ------------------------------------------------------------
	// read data selection
	// ------------------------------------------------------------
	// 07 and 26 live in this module, other globals in the global bank
	always_comb
	begin
		rd_value = 8'h00;
		if (!idx_valid)
			rd_value = 8'h00;
		else if (s_r.index == cfg_pkg::IDX_LDN)
			rd_value = s_r.ldn;
		else if (s_r.index == cfg_pkg::IDX_OPTION)
			rd_value = s_r.option;
		else if (s_r.index < cfg_pkg::IDX_BANK_LO)
			rd_value = glob_rd;
		else if (s_r.ldn < 8'(cfg_pkg::LDN_COUNT))
			rd_value = dev_rd[s_r.ldn[3:0]];
		else
			rd_value = 8'h00;
	end

	// ------------------------------------------------------------
	// sequence and register update
	// ------------------------------------------------------------
	always_comb
	begin
		s_nxt          = s_r;
		bank_wr        = 1'b0;
		glob_wr        = 1'b0;
		s_nxt.iow_prev = pins.iow_n;

		case (s_r.mode)
			cfg_pkg::MODE_NORMAL:
			begin
				if (io_write && at_index && pins.data == cfg_pkg::KEY_ENTER)
					s_nxt.mode = cfg_pkg::MODE_KEY1;
			end
			cfg_pkg::MODE_KEY1:
			begin
				if (io_write && at_index && pins.data == cfg_pkg::KEY_ENTER)
					s_nxt.mode = cfg_pkg::MODE_EXT;
				else if (io_write && (at_index || at_data))
					s_nxt.mode = cfg_pkg::MODE_NORMAL;
			end
			cfg_pkg::MODE_EXT:
			begin
				if (io_write && at_index)
				begin
					if (pins.data == cfg_pkg::KEY_EXIT)
						s_nxt.mode = cfg_pkg::MODE_NORMAL;
					else
						s_nxt.index = pins.data;
				end
				else if (io_write && at_data && idx_valid
					&& (!locked || s_r.index == cfg_pkg::IDX_OPTION))
				begin
					if (s_r.index == cfg_pkg::IDX_LDN)
						s_nxt.ldn = pins.data;
					else if (s_r.index == cfg_pkg::IDX_OPTION)
						s_nxt.option = pins.data;
					else if (s_r.index >= cfg_pkg::IDX_BANK_LO)
						bank_wr = 1'b1;
					else
						glob_wr = 1'b1;
				end
			end
			default:
			begin
				s_nxt.mode = cfg_pkg::MODE_NORMAL;
			end
		endcase

		// data port drives only while a read is under way
		if (io_read)
		begin
			s_nxt.dout = rd_value;
			s_nxt.oe_n = 1'b0;
		end
		else
		begin
			s_nxt.dout = 8'h00;
			s_nxt.oe_n = 1'b1;
		end

		// warm reset restarts access, clears the index and idles the data port; ldn, option and the banks keep their values
		if (pins.warm_rst)
		begin
			s_nxt.mode  = cfg_pkg::MODE_NORMAL;
			s_nxt.index = cfg_pkg::INDEX_RESET;
			s_nxt.oe_n  = 1'b1;
			s_nxt.dout  = 8'h00;
			bank_wr     = 1'b0;
			glob_wr     = 1'b0;
		end

		// strap is caught once, when the synchroniser shows the pin
		if (strap_busy)
		begin
			s_nxt.strap_cnt = s_r.strap_cnt + 2'h1;
			s_nxt.mode      = cfg_pkg::MODE_NORMAL;
			bank_wr         = 1'b0;
			glob_wr         = 1'b0;
			if (strap_take)
				s_nxt.option[cfg_pkg::OPT_PORT_SEL_BIT] = pins.strap;
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	// cold reset clears all; warm reset acts in the sequence logic
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			s_r <= '{mode: cfg_pkg::MODE_NORMAL,
				index: cfg_pkg::INDEX_RESET,
				ldn: cfg_pkg::LDN_RESET,
				option: cfg_pkg::OPTION_RESET,
				strap_cnt: 2'h0,
				iow_prev: 1'b1,
				dout: 8'h00,
				oe_n: 1'b1};
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign isa_data_out       = s_r.dout;
	// low only while a data port read is served
	assign isa_data_oe_n      = s_r.oe_n;
	assign config_mode        = s_r.mode[2];
	assign logical_device     = s_r.ldn;
	assign config_port_select = s_r.option[cfg_pkg::OPT_PORT_SEL_BIT];

endmodule

/* logic/cfg_pkg.sv */
/*
 * Constants, state encodings and carrier structs of the configuration
 * unlock / index / data port block.
 * Assumes an ISA-style I/O bus with a 10-bit decoded I/O address.
 */
package cfg_pkg;

	// ------------------------------------------------------------
	// addresses and key values
	// ------------------------------------------------------------
	localparam int        ADDR_W        = 10;
	localparam logic [9:0] BASE_PRIMARY = 10'h3F0;
	localparam logic [9:0] DATA_PRIMARY = 10'h3F1;
	localparam logic [9:0] BASE_ALT     = 10'h370;
	localparam logic [9:0] DATA_ALT     = 10'h371;
	localparam logic [7:0] KEY_ENTER    = 8'h87;
	localparam logic [7:0] KEY_EXIT     = 8'hAA;

	// ------------------------------------------------------------
	// index map
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_GLOBAL_CTRL = 8'h02;
	localparam logic [7:0] IDX_LDN         = 8'h07;
	localparam logic [7:0] IDX_RANGE_LO    = 8'h07;
	localparam logic [7:0] IDX_RANGE_HI    = 8'hFE;
	localparam logic [7:0] IDX_OPTION      = 8'h26;
	localparam logic [7:0] IDX_GLOBAL_LAST = 8'h2F;
	localparam logic [7:0] IDX_BANK_LO     = 8'h30;

	// ------------------------------------------------------------
	// fields and reset values
	// ------------------------------------------------------------
	localparam int         OPT_PORT_SEL_BIT = 6;
	localparam int         OPT_LOCK_BIT     = 5;
	localparam logic [7:0] OPTION_RESET     = 8'h00;
	localparam logic [7:0] LDN_RESET        = 8'h00;
	localparam logic [7:0] INDEX_RESET      = 8'h00;
	localparam logic [7:0] CFG_RESET        = 8'h00;
	localparam int         LDN_COUNT        = 11;
	localparam int         LDN_SKIPPED      = 4;
	localparam logic [1:0] STRAP_TAKE       = 2'h2;
	localparam logic [1:0] STRAP_DONE       = 2'h3;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_NORMAL = 3'b001,
		MODE_KEY1   = 3'b010,
		MODE_EXT    = 3'b100
	} mode_e;

	typedef struct packed {
		logic              warm_rst;
		logic              strap;
		logic              aen;
		logic              iow_n;
		logic              ior_n;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        data;
	} pins_s;

	localparam pins_s PINS_IDLE = '{warm_rst: 1'b0, strap: 1'b0, aen: 1'b1,
		iow_n: 1'b1, ior_n: 1'b1, addr: 10'h000, data: 8'h00};

endpackage

/* logic/sync2.sv */
/*
 * Two flip-flop synchroniser for a vector of asynchronous pins.
 * Assumes each bit is independent or held stable around its strobe.
 */
`timescale 1ns/100ps
module sync2 #(
	parameter int              WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} state_s;

	state_s s_r;
	state_s s_nxt;

	initial
	begin
		if (WIDTH < 1)
			$error("sync2 width must be at least one");
	end

	always_comb
	begin
		s_nxt        = s_r;
		s_nxt.meta   = d;
		s_nxt.stable = s_r.meta;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			s_r <= '{meta: RESET_VAL, stable: RESET_VAL};
		else
			s_r <= s_nxt;
	end

	assign q = s_r.stable;

endmodule

/* logic/cfg_byte_bank.sv */
/*
 * Bank of byte-wide configuration registers covering indices FIRST..LAST.
 * Assumes the caller qualifies wr_en; reset is the cold reset only.
 */
`timescale 1ns/100ps
module cfg_byte_bank #(
	parameter logic [7:0] FIRST = 8'h30,
	parameter logic [7:0] LAST  = 8'hFE
) (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       wr_en,
	input  wire logic [7:0] idx,
	input  wire logic [7:0] wr_data,
	output logic      [7:0] rd_data
);

	localparam int DEPTH = int'(LAST) - int'(FIRST) + 1;

	typedef struct packed {
		logic [DEPTH-1:0][7:0] mem;
	} state_s;

	state_s     s_r;
	state_s     s_nxt;
	logic       in_range;
	logic [7:0] offset;

	initial
	begin
		if (LAST < FIRST)
			$error("cfg_byte_bank range is empty");
	end

	assign in_range = (idx >= FIRST) && (idx <= LAST);
	assign offset   = idx - FIRST;

	always_comb
	begin
		s_nxt = s_r;
		if (wr_en && in_range)
			s_nxt.mem[offset] = wr_data;
	end

	// cold reset only; warm reset never reaches this bank
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			s_r <= '{mem: {DEPTH{cfg_pkg::CFG_RESET}}};
		else
			s_r <= s_nxt;
	end

	assign rd_data = in_range ? s_r.mem[offset] : 8'h00;

endmodule

/* test/cfg_port_props.sv */
/*
 * Checker of the configuration port block, bound to its top module.
 * Assumes bus strobes low and high for three or more cycles.
 */
`timescale 1ns/100ps
module cfg_port_props (
	input wire logic       clock,
	input wire logic       rst,
	input wire logic       warm_rst,
	input wire logic       isa_aen,
	input wire logic [9:0] isa_addr,
	input wire logic       isa_iow_n,
	input wire logic       isa_ior_n,
	input wire logic [7:0] isa_data_in,
	input wire logic [7:0] isa_data_out,
	input wire logic       isa_data_oe_n,
	input wire logic       config_mode,
	input wire logic [7:0] logical_device,
	input wire logic       config_port_select
);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	drive_needs_mode_a: assert property (!isa_data_oe_n |-> config_mode)
		else $error("data bus driven outside config mode");
	idle_data_zero_a: assert property (isa_data_oe_n |-> isa_data_out == 8'h00)
		else $error("read data not zero while idle");
	read_strobe_a: assert property ($fell(isa_data_oe_n) |->
		!$past(isa_ior_n, 1) && !$past(isa_ior_n, 2))
		else $error("data bus driven without read strobe");
	read_addr_a: assert property ($fell(isa_data_oe_n) |-> !$past(isa_aen, 1) &&
		$past(isa_addr, 1) == (config_port_select ? cfg_pkg::DATA_ALT : cfg_pkg::DATA_PRIMARY))
		else $error("data bus driven for wrong address");
	unlock_key_a: assert property ($rose(config_mode) |-> $past(isa_iow_n, 1) &&
		$past(isa_data_in, 2) == 8'h87 && !$past(isa_aen, 2) &&
		$past(isa_addr, 2) == (config_port_select ? 10'h370 : 10'h3F0))
		else $error("config mode entered without key");
	exit_key_a: assert property ($fell(config_mode) |-> $past(warm_rst, 1) ||
		$past(warm_rst, 2) || ($past(isa_data_in, 2) == 8'hAA && $past(isa_iow_n, 1)))
		else $error("config mode left without exit key");
	ldn_change_a: assert property ($changed(logical_device) |-> $past(config_mode) &&
		$past(isa_iow_n, 1))
		else $error("device number changed outside config write");
	port_sel_change_a: assert property ($changed(config_port_select) |->
		$past(rst, 4) || $past(config_mode))
		else $error("port select changed without cause");
endmodule

bind config_unlock_index_data_port cfg_port_props chk (
	.clock(clock),
	.rst(rst),
	.warm_rst(warm_rst),
	.isa_aen(isa_aen),
	.isa_addr(isa_addr),
	.isa_iow_n(isa_iow_n),
	.isa_ior_n(isa_ior_n),
	.isa_data_in(isa_data_in),
	.isa_data_out(isa_data_out),
	.isa_data_oe_n(isa_data_oe_n),
	.config_mode(config_mode),
	.logical_device(logical_device),
	.config_port_select(config_port_select)
);

/* test/host_bus.sv */
/*
 * Host model on the I/O bus: write and read cycles on the falling edge.
 * Assumes the bench supplies the clock and the block's read outputs.
 */
`timescale 1ns/100ps
module host_bus (
	input  wire logic       clock,
	input  wire logic [7:0] dout,
	input  wire logic       doe_n,
	output logic            aen,
	output logic      [9:0] addr,
	output logic            iow_n,
	output logic            ior_n,
	output logic      [7:0] data
);
	// ------------------------------------------------------------
	// bus cycles
	// ------------------------------------------------------------
	initial
	begin
		aen = 1'b1;
		addr = 10'h000;
		iow_n = 1'b1;
		ior_n = 1'b1;
		data = 8'h00;
	end

	// strobe low 4, high 6 cycles; released data shows inverse
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		aen = 1'b0;
		addr = a;
		data = d;
		iow_n = 1'b0;
		repeat (4) @(negedge clock);
		iow_n = 1'b1;
		repeat (6) @(negedge clock);
		aen = 1'b1;
		data = ~d;
		@(negedge clock);
	endtask

	task automatic rd(input logic [9:0] a, output logic [7:0] d, output logic oe);
		aen = 1'b0;
		addr = a;
		ior_n = 1'b0;
		repeat (5) @(negedge clock);
		d = dout;
		oe = doe_n;
		ior_n = 1'b1;
		repeat (6) @(negedge clock);
		aen = 1'b1;
		@(negedge clock);
	endtask
endmodule

/* test/test_config_unlock_index_data_port.sv */
/*
 * Self-checking bench of the configuration port block.
 * Assumes host_bus as bus partner and the checker bound to the block.
 */
`timescale 1ns/100ps
module test_config_unlock_index_data_port;
	logic       clock;
	logic       rst;
	logic       warm_rst;
	logic       strap;
	logic       aen;
	logic [9:0] addr;
	logic       iow_n;
	logic       ior_n;
	logic [7:0] din;
	logic [7:0] dout;
	logic       oe_n;
	logic       mode;
	logic [7:0] ldn;
	logic       psel;
	logic [7:0] v;
	logic       oe;
	logic [9:0] b;
	int         bad_count;
	int         n_checks;

	host_bus host (.clock(clock), .dout(dout), .doe_n(oe_n), .aen(aen), .addr(addr),
		.iow_n(iow_n), .ior_n(ior_n), .data(din));

	config_unlock_index_data_port DUT (.clock(clock), .rst(rst), .warm_rst(warm_rst),
		.port_select_strap_pin(strap), .isa_aen(aen), .isa_addr(addr),
		.isa_iow_n(iow_n), .isa_ior_n(ior_n), .isa_data_in(din), .isa_data_out(dout),
		.isa_data_oe_n(oe_n), .config_mode(mode), .logical_device(ldn),
		.config_port_select(psel));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cold(input logic s);
		rst = 1'b1;
		strap = s;
		repeat (6) @(negedge clock);
		rst = 1'b0;
		repeat (3) @(negedge clock);
	endtask

	task automatic enter;
		host.wr(b, 8'h87);
		host.wr(b, 8'h87);
	endtask

	task automatic set(input logic [7:0] i, input logic [7:0] d);
		host.wr(b, i);
		host.wr(b + 10'h001, d);
	endtask

	task automatic get(input logic [7:0] i);
		host.wr(b, i);
		host.rd(b + 10'h001, v, oe);
	endtask

	task automatic final_report;
		$display("checks %0d errors %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_unlock;
		check({7'h00, psel}, 8'h00);
		set(8'h07, 8'h05);
		host.rd(b + 10'h001, v, oe);
		check({7'h00, oe}, 8'h01);
		check(ldn, 8'h00);
		host.wr(b, 8'h87);
		host.wr(b, 8'h11);
		host.wr(b, 8'h87);
		host.wr(b + 10'h001, 8'h00);
		host.wr(b, 8'h87);
		check({7'h00, mode}, 8'h00);
		host.wr(b, 8'h87);
		check({7'h00, mode}, 8'h01);
	endtask

	task automatic t_banks;
		set(8'h07, 8'h03);
		check(ldn, 8'h03);
		set(8'h30, 8'h5A);
		set(8'h07, 8'h05);
		set(8'h30, 8'hA5);
		set(8'h20, 8'h33);
		set(8'h07, 8'h03);
		get(8'h30);
		check(v, 8'h5A);
		check({7'h00, oe}, 8'h00);
		get(8'h20);
		check(v, 8'h33);
		set(8'h02, 8'h4C);
		get(8'h02);
		check(v, 8'h4C);
		set(8'h07, 8'h04);
		set(8'h30, 8'h77);
		get(8'h30);
		check(v, 8'h00);
		get(8'hFF);
		check(v, 8'h00);
		host.rd(b, v, oe);
		check({7'h00, oe}, 8'h01);
	endtask

	task automatic t_lock;
		set(8'h07, 8'h03);
		set(8'h26, 8'h20);
		set(8'h30, 8'h11);
		get(8'h30);
		check(v, 8'h5A);
		set(8'h26, 8'h00);
		set(8'h30, 8'h11);
		get(8'h30);
		check(v, 8'h11);
	endtask

	task automatic t_warm_exit;
		warm_rst = 1'b1;
		repeat (4) @(negedge clock);
		warm_rst = 1'b0;
		repeat (4) @(negedge clock);
		check({7'h00, mode}, 8'h00);
		check(ldn, 8'h03);
		enter();
		get(8'h30);
		check(v, 8'h11);
		host.wr(b, 8'hAA);
		check({7'h00, mode}, 8'h00);
		set(8'h07, 8'h01);
		check(ldn, 8'h03);
	endtask

	task automatic t_alt_port;
		cold(1'b1);
		check({7'h00, psel}, 8'h01);
		check(ldn, 8'h00);
		enter();
		check({7'h00, mode}, 8'h00);
		b = 10'h370;
		enter();
		check({7'h00, mode}, 8'h01);
		set(8'h07, 8'h03);
		get(8'h30);
		check(v, 8'h00);
		get(8'h07);
		check(v, 8'h03);
	endtask

	initial
	begin
		#200000;
		bad_count++;
		final_report();
	end

	initial
	begin
		bad_count = 0;
		n_checks = 0;
		warm_rst = 1'b0;
		b = 10'h3F0;
		cold(1'b0);
		t_unlock();
		t_banks();
		t_lock();
		t_warm_exit();
		t_alt_port();
		final_report();
	end
endmodule
